// ==== hw/uarx_pkg.sv ====
// package for the asynchronous receive recovery block
package uarx_pkg;
  localparam int SAMPLES_NORMAL = 16;
  localparam int SAMPLES_DOUBLE = 8;
  localparam logic [3:0] VOTE_FIRST_NORMAL = 4'h8;
  localparam logic [3:0] VOTE_FIRST_DOUBLE = 4'h4;
  localparam logic [3:0] DATA_BITS_MIN = 4'h5;
  localparam logic [3:0] DATA_BITS_MAX = 4'ha;
  localparam logic [3:0] DATA_BITS_RESET = 4'h8;
  localparam int FRAME_WIDTH = 10;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic [FRAME_WIDTH-1:0] data;
    logic [3:0] bitCount;
    logic stopBitErrorFlag;
  } uarx_frame_t;
endpackage : uarx_pkg

// ==== hw/uarx_rx_recovery.sv ====
// receive recovery front end with its frame fifo
`timescale 1ns/1ps

// ****************************************************************
// frame fifo
// ****************************************************************
module uarx_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] wrPtr_next;
  logic [AW-1:0] rdPtr_reg;
  logic [AW-1:0] rdPtr_next;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic doWrite;
  logic doRead;

  // full and empty both come from the one count, so no pointer race
  assign inReady = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = mem_reg[rdPtr_reg];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  always_comb begin
    mem_next = mem_reg;
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    count_next = count_reg;
    if (doWrite) begin
      mem_next[wrPtr_reg] = inData;
      wrPtr_next = (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
    end
    if (doRead) begin
      rdPtr_next = (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
    end
    if (doWrite && !doRead) begin
      count_next = count_reg + 1'b1;
    end else if (doRead && !doWrite) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end
endmodule : uarx_fifo

// Summary of operation
// - sample line at 16x, or 8x double
// - idle-high to low starts; first low sample 1
// - start checked on samples 8-10 or 4-6
// - two high votes reject start as noise
// - valid start realigns bit timing every frame
// - per-bit sample state, 16 or 8 states
// - bit value from three centre samples
// - majority of three decides bit value
// - recover data, parity, first stop only
// - stop voted zero sets frame error flag
// - normal mode: next start right after voting
// - data plus parity five to ten bits
// - frame error stored with its frame
module uarx_rx_recovery #(
  parameter int DEPTH = uarx_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sampleTick,
  input wire logic double_speed_select,
  input wire logic [3:0] frameBits,
  input wire logic serial_rx_line,
  output logic frameValid,
  input wire logic frameReady,
  output uarx_pkg::uarx_frame_t frameOut,
  output logic frameDropped
);
  import uarx_pkg::*;

  // ****************************************************************
  // line synchroniser and state
  // ****************************************************************
  typedef enum logic [3:0] {
    UARX_IDLE = 4'b0001,
    UARX_START = 4'b0010,
    UARX_BITS = 4'b0100,
    UARX_STOP = 4'b1000
  } uarx_state_t;

  logic syncA_reg;
  logic syncB_reg;
  logic lineLast_reg;
  logic syncA_next;
  logic syncB_next;
  logic lineLast_next;
  uarx_state_t state_reg, state_next;
  logic [3:0] sample_reg, sample_next;
  logic [2:0] votes_reg, votes_next;
  logic [3:0] bitIdx_reg, bitIdx_next;
  logic [3:0] bitsLatched_reg, bitsLatched_next;
  logic speedLatched_reg, speedLatched_next;
  logic [FRAME_WIDTH-1:0] shift_reg;
  wire logic [FRAME_WIDTH-1:0] shift_next;
  logic pushValid_reg, pushValid_next;
  uarx_frame_t push_reg, push_next;
  logic dropped_reg, dropped_next;
  logic pushReady;

  logic [3:0] voteFirst;
  logic [3:0] lastSample;
  logic [3:0] bitsClamped;
  logic voteBit;
  logic fallEdge;
  logic inVote;
  logic voteDone;
  logic bitVote;
  logic frameDone;

  always_comb begin
    syncA_next = serial_rx_line;
    syncB_next = syncA_reg;
  end

  // resets to idle high so no false start edge follows reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      syncA_reg <= 1'b1;
      syncB_reg <= 1'b1;
    end else begin
      syncA_reg <= syncA_next;
      syncB_reg <= syncB_next;
    end
  end

  // ****************************************************************
  // sample timing helpers
  // ****************************************************************
  // mode is latched at the start edge so a mid-frame change cannot
  // tear the bit timing apart
  always_comb begin
    voteFirst = speedLatched_reg ? VOTE_FIRST_DOUBLE
                                 : VOTE_FIRST_NORMAL;
    lastSample = speedLatched_reg ? 4'(SAMPLES_DOUBLE - 1)
                                  : 4'(SAMPLES_NORMAL - 1);
    inVote = (sample_reg >= voteFirst) &&
             (sample_reg <= voteFirst + 4'h2);
    voteDone = (sample_reg == voteFirst + 4'h2);
    bitVote = sampleTick && voteDone && (state_reg == UARX_BITS);
    // two or three of three decides
    voteBit = (votes_reg[0] & votes_reg[1]) | (votes_reg[0] & syncB_reg) |
              (votes_reg[1] & syncB_reg);
    fallEdge = lineLast_reg && !syncB_reg;
    if (frameBits < DATA_BITS_MIN) begin
      bitsClamped = DATA_BITS_MIN;
    end else if (frameBits > DATA_BITS_MAX) begin
      bitsClamped = DATA_BITS_MAX;
    end else begin
      bitsClamped = frameBits;
    end
  end

  // ****************************************************************
  // receive shifter, one flip-flop per bit position
  // ****************************************************************
  // only the position being voted moves; the others keep their value
  for (genvar b = 0; b < FRAME_WIDTH; b++) begin : g_shiftBit
    assign shift_next[b] = (bitVote && (bitIdx_reg == 4'(b))) ?
                           voteBit : shift_reg[b];
  end

  // ****************************************************************
  // recovery state machine
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    sample_next = sample_reg;
    votes_next = votes_reg;
    bitIdx_next = bitIdx_reg;
    bitsLatched_next = bitsLatched_reg;
    speedLatched_next = speedLatched_reg;
    lineLast_next = lineLast_reg;
    frameDone = 1'b0;
    if (sampleTick) begin
      lineLast_next = syncB_reg;
      // vote shifter: sample_reg is the number of the current sample
      if (inVote) begin
        votes_next = {votes_reg[1:0], syncB_reg};
      end
      case (state_reg)
        UARX_IDLE: begin
          if (fallEdge) begin
            state_next = UARX_START;
            sample_next = 4'h2; // this tick was sample 1
            speedLatched_next = double_speed_select;
            bitsLatched_next = bitsClamped;
          end
        end
        UARX_START: begin
          sample_next = sample_reg + 4'h1;
          if (voteDone) begin
            // clear the shifter view: votes_reg holds samples 1,2 of 3
            if ({votes_reg[1:0], syncB_reg} inside
                {3'h3, 3'h5, 3'h6, 3'h7}) begin
              state_next = UARX_IDLE;
            end
          end
          if (sample_reg == lastSample) begin
            state_next = UARX_BITS;
            sample_next = 4'h0;
            bitIdx_next = 4'h0;
          end
        end
        UARX_BITS: begin
          sample_next = (sample_reg == lastSample) ? 4'h0
                                                   : sample_reg + 4'h1;
          if (sample_reg == lastSample) begin
            bitIdx_next = bitIdx_reg + 4'h1;
            if (bitIdx_reg == bitsLatched_reg - 4'h1) begin
              state_next = UARX_STOP;
            end
          end
        end
        UARX_STOP: begin
          sample_next = sample_reg + 4'h1;
          if (voteDone) begin
            // later stop bits are never looked at
            frameDone = 1'b1;
            // normal mode may start the next frame one sample on
            state_next = speedLatched_reg ? UARX_STOP : UARX_IDLE;
          end else if (sample_reg > voteFirst + 4'h2) begin
            state_next = UARX_IDLE;
          end
        end
        default: begin
          state_next = UARX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lineLast_reg <= 1'b1;
      state_reg <= UARX_IDLE;
      sample_reg <= 4'h0;
      votes_reg <= 3'h7;
      bitIdx_reg <= 4'h0;
      bitsLatched_reg <= DATA_BITS_RESET;
      speedLatched_reg <= 1'b0;
      shift_reg <= '0;
    end else begin
      lineLast_reg <= lineLast_next;
      state_reg <= state_next;
      sample_reg <= sample_next;
      votes_reg <= votes_next;
      bitIdx_reg <= bitIdx_next;
      bitsLatched_reg <= bitsLatched_next;
      speedLatched_reg <= speedLatched_next;
      shift_reg <= shift_next;
    end
  end

  // ****************************************************************
  // push stage in front of the buffer
  // ****************************************************************
  // a frame that finds the stage still full is lost whole; the frame
  // already waiting keeps its contents untouched
  always_comb begin
    pushValid_next = pushValid_reg && !pushReady;
    push_next = push_reg;
    dropped_next = 1'b0;
    if (frameDone) begin
      if (pushValid_reg && !pushReady) begin
        dropped_next = 1'b1;
      end else begin
        pushValid_next = 1'b1;
        push_next.data = shift_reg;
        push_next.bitCount = bitsLatched_reg;
        push_next.stopBitErrorFlag = !voteBit;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pushValid_reg <= 1'b0;
      push_reg <= '0;
      dropped_reg <= 1'b0;
    end else begin
      pushValid_reg <= pushValid_next;
      push_reg <= push_next;
      dropped_reg <= dropped_next;
    end
  end

  assign frameDropped = dropped_reg;

  // ****************************************************************
  // frame buffer
  // ****************************************************************
  uarx_fifo #(
    .WIDTH($bits(uarx_frame_t)),
    .DEPTH(DEPTH)
  ) frameFifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .inValid(pushValid_reg),
    .inReady(pushReady),
    .inData(push_reg),
    .outValid(frameValid),
    .outReady(frameReady),
    .outData(frameOut)
  );
endmodule : uarx_rx_recovery

// ==== verif/test_uarx_rx_recovery.sv ====
// testbench for the receive recovery block
`timescale 1ns/1ps
module test_uarx_rx_recovery;
  import uarx_pkg::*;
  logic core_clk, rstn, sampleTick, double_speed_select, serial_rx_line;
  logic frameValid, frameReady, frameDropped, hold, dropSeen;
  logic [3:0] frameBits;
  logic [1:0] tickCnt;
  logic [31:0] rnd;
  uarx_frame_t frameOut, e, g, expQ[$];
  int error_cnt, checks;

  uarx_rx_recovery #(.DEPTH(8)) DUT (.core_clk(core_clk), .rstn(rstn),
    .sampleTick(sampleTick), .double_speed_select(double_speed_select),
    .frameBits(frameBits), .serial_rx_line(serial_rx_line),
    .frameValid(frameValid), .frameReady(frameReady),
    .frameOut(frameOut), .frameDropped(frameDropped));
  uarx_tx_model MODEL (.core_clk(core_clk), .sampleTick(sampleTick),
    .line(serial_rx_line));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  // **********************************
  // tick every fourth cycle, random consumer stalls
  // **********************************
  always @(posedge core_clk) begin
    rnd <= lfsr(rnd);
    tickCnt <= tickCnt + 2'h1;
    sampleTick <= (tickCnt == 2'h3);
    frameReady <= !hold && rnd[0];
  end

  task automatic cmp(input logic [14:0] got, input logic [14:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  always @(posedge core_clk) begin
    if (frameDropped === 1'b1) begin
      dropSeen = 1'b1;
      void'(expQ.pop_back());
    end
    if (frameValid === 1'b1 && frameReady === 1'b1) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : 'x;
      g = frameOut;
      g.data = g.data & ((10'h1 << e.bitCount) - 10'h1);
      cmp(g, e);
    end
  end

  task automatic frame(input bit d, input int n, input bit bad, input bit sh);
    logic [31:0] v;
    v = rnd;
    e.data = v[9:0] & ((10'h1 << n) - 10'h1);
    e.bitCount = 4'(n);
    e.stopBitErrorFlag = bad;
    expQ.push_back(e);
    double_speed_select <= d;
    frameBits <= 4'(n);
    MODEL.send(d, n, v[9:0], bad, v[10], sh);
  endtask : frame

  task automatic end_sim();
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    {rstn, sampleTick, frameReady, hold, dropSeen} = 5'h00;
    {double_speed_select, tickCnt, frameBits} = 7'h08;
    rnd = 32'h13ba8;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    MODEL.put(1'b1, 4, 0, 1'b0);
    for (int n = 5; n <= 10; n++)
      for (int d = 0; d < 2; d++) frame(1'(d), n, 1'b0, 1'b0);
    for (int d = 0; d < 2; d++) begin
      MODEL.spike();
      frame(1'(d), 8, 1'b1, 1'b0);
      repeat (4) frame(1'(d), 7, 1'b0, 1'b1);
      frame(1'(d), 7, 1'b0, 1'b0);
    end
    hold <= 1'b1;
    repeat (11) frame(1'b1, 6, 1'b0, 1'b0);
    hold <= 1'b0;
    // long idle line lets the idle-line check see its antecedent
    MODEL.put(1'b1, 250, 0, 1'b0);
    cmp({14'h0, dropSeen}, 15'h1);
    cmp(15'(expQ.size()), 15'h0);
    end_sim();
  end

  initial begin
    #400000;
    error_cnt++;
    end_sim();
  end
endmodule : test_uarx_rx_recovery

bind uarx_rx_recovery uarx_rx_recovery_assertions #(.TICK(4)) u_chk (
  .core_clk(core_clk), .rstn(rstn), .serial_rx_line(serial_rx_line),
  .frameValid(frameValid), .frameReady(frameReady), .frameOut(frameOut),
  .frameDropped(frameDropped));

// ==== verif/uarx_rx_recovery_assertions.sv ====
// checker for the receive recovery block
`timescale 1ns/1ps
module uarx_rx_recovery_assertions import uarx_pkg::*; #(
  parameter int TICK = 4
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic serial_rx_line,
  input wire logic frameValid,
  input wire logic frameReady,
  input wire uarx_pkg::uarx_frame_t frameOut,
  input wire logic frameDropped
);
  // longest all-high run that still closes a frame is under 12 bits
  localparam int IDLE = 12 * 16 * TICK;
  logic [11:0] hiCnt_reg;
  logic [11:0] hiCnt_next;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  always_comb hiCnt_next = serial_rx_line ? hiCnt_reg + 12'h001 : 12'h000;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hiCnt_reg <= 12'h000;
    end else begin
      hiCnt_reg <= hiCnt_next;
    end
  end
  property p_resetClear;
    $rose(rstn) |-> frameOut == '0;
  endproperty
  a_resetClear: assert property (p_resetClear)
    else $error("output not cleared by reset");
  property p_noEarlyFrame;
    $rose(rstn) |-> !frameValid [*8];
  endproperty
  a_noEarlyFrame: assert property (p_noEarlyFrame)
    else $error("frame without start bit");
  property p_dropPulse;
    frameDropped |=> !frameDropped;
  endproperty
  a_dropPulse: assert property (p_dropPulse)
    else $error("drop pulse too long");
  property p_dropFull;
    frameDropped |-> frameValid;
  endproperty
  a_dropFull: assert property (p_dropFull)
    else $error("drop with empty buffer");
  property p_holdValid;
    frameValid && !frameReady |=> frameValid;
  endproperty
  a_holdValid: assert property (p_holdValid)
    else $error("frame vanished unread");
  property p_holdData;
    frameValid && !frameReady |=> $stable(frameOut);
  endproperty
  a_holdData: assert property (p_holdData)
    else $error("frame changed unread");
  property p_bitRange;
    frameValid |-> frameOut.bitCount inside {[4'h5:4'ha]};
  endproperty
  a_bitRange: assert property (p_bitRange)
    else $error("bit count out of range");
  property p_idleNone;
    int'(hiCnt_reg) > IDLE |-> !$rose(frameValid);
  endproperty
  a_idleNone: assert property (p_idleNone)
    else $error("frame from idle line");
endmodule : uarx_rx_recovery_assertions

// ==== verif/uarx_tx_model.sv ====
// far-end serial transmitter model
`timescale 1ns/1ps
module uarx_tx_model (
  input wire logic core_clk,
  input wire logic sampleTick,
  output logic line
);
  initial line = 1'b1;
  // one level for n ticks, inverted on tick c to test the vote
  task automatic put(input logic b, input int n, input int c, input bit gl);
    for (int s = 1; s <= n; s++) begin
      @(posedge core_clk iff sampleTick);
      line <= (gl && s == c) ? ~b : b;
    end
  endtask : put
  task automatic send(input bit ds, input int nb, input logic [9:0] d,
    input bit bad, input bit gl, input bit sh);
    int s;
    s = ds ? 8 : 16;
    put(1'b0, s, s / 2, gl);
    for (int i = 0; i < nb; i++) put(d[i], s, s / 2 + 1, gl);
    // a short stop ends right after the last voting sample, one sample later in double speed
    put(~bad, sh ? s / 2 + 2 + int'(ds) : s, 0, 1'b0);
    if (!sh) put(1'b1, 2, 0, 1'b0);
  endtask : send
  task automatic spike();
    put(1'b0, 3, 0, 1'b0);
    put(1'b1, 16, 0, 1'b0);
  endtask : spike
endmodule : uarx_tx_model
